// [hw/cme_pkg.sv]
// Shared constants and types of the channel mode engine
package cme_pkg;

  // Channel and pin geometry
  localparam int NUM_CH = 4;          // Channels in the bridge
  localparam int SSE_CH = 2;          // Channels that carry the serial engine
  localparam int PIN_W = 8;           // Parallel port width
  localparam int PRESCALE_W = 14;     // Baud prescaler width
  localparam int FRAC_W = 4;          // Baud fine-tuning bits
  localparam int DIV_W = 8;           // Serial clock divisor width

  // Channel mode codes
  localparam logic [7:0] MODE_UART = 8'h00;
  localparam logic [7:0] MODE_ASYNC_BB = 8'h01;
  localparam logic [7:0] MODE_SSE = 8'h02;
  localparam logic [7:0] MODE_SYNC_BB = 8'h04;

  // Serial engine opcodes carried in the host stream
  localparam logic [7:0] OP_SET_DIV = 8'h01;
  localparam logic [7:0] OP_ADAPT_ON = 8'h02;
  localparam logic [7:0] OP_ADAPT_OFF = 8'h03;
  localparam logic [7:0] OP_SHIFT = 8'h10;

  // Serial engine pin positions on the parallel port
  localparam int PIN_CLK = 0;         // Serial clock out
  localparam int PIN_DOUT = 1;        // Serial data out
  localparam int PIN_DIN = 2;         // Serial data in
  localparam int PIN_RCLK = 7;        // Low GPIO bit 3, returned clock
  localparam logic [7:0] SSE_OUT_MASK = 8'h03;

  // Clock rates
  localparam int CLK_HZ = 10_000_000;
  localparam int SSE_MAX_BPS = 30_000_000;  // Ceiling of the engine rate
  localparam int SSE_BASE_HZ = CLK_HZ / 2;  // Fastest serial clock here

  // UART framing
  localparam logic [3:0] UART_OVERSAMPLE_LAST = 4'hF;  // x16 ticks per bit
  localparam logic [3:0] UART_BITS_ONE_STOP = 4'hA;
  localparam logic [3:0] UART_BITS_TWO_STOP = 4'hB;

  // Synchronous bit-bang settle: one setup cycle plus pin sync latency
  localparam int SBB_SETUP_CYCLES = 1;
  localparam int PIN_SYNC_LATENCY = 3;
  localparam logic [2:0] SBB_SETTLE =
    3'(SBB_SETUP_CYCLES + PIN_SYNC_LATENCY);

  // Reset values
  localparam logic [7:0] RST_PIN_OUT = 8'h00;
  localparam logic [7:0] RST_DIV = 8'h00;

  // Baud generator setting
  typedef struct packed {
    logic [PRESCALE_W-1:0] prescale;
    logic [FRAC_W-1:0] frac;
  } cme_baud_cfg_type;

  // Per-channel line setting
  typedef struct packed {
    logic two_stop;
    cme_baud_cfg_type baud;
  } cme_line_cfg_type;

  // Channel sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_UART_TX,
    ST_SETTLE,
    ST_SSE_ARG,
    ST_SSE_LOW,
    ST_SSE_WAIT_RCLK,
    ST_SSE_HIGH
  } cme_state_type;

endpackage

// [hw/cme_baud_tick.sv]
// Fractional baud tick generator
`timescale 1ns/1ps
`default_nettype none

module cme_baud_tick #(
  parameter int PRESCALE_W = cme_pkg::PRESCALE_W,
  parameter int FRAC_W = cme_pkg::FRAC_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Setting
  input wire logic [PRESCALE_W-1:0] prescale,
  input wire logic [FRAC_W-1:0] frac,
  // Tick out
  output logic tick
);

  logic [PRESCALE_W-1:0] count;  // Cycles left in this period
  logic [FRAC_W-1:0] acc;        // Fraction accumulator

  // Fraction carry stretches a period by one cycle
  wire [FRAC_W:0] acc_sum = {1'b0, acc} + {1'b0, frac};
  wire carry = acc_sum[FRAC_W];
  // Zero prescale behaves as one, so the tick never stalls
  wire [PRESCALE_W-1:0] base =
    (prescale == '0) ? '0 : prescale - {{(PRESCALE_W-1){1'b0}}, 1'b1};
  wire [PRESCALE_W-1:0] reload = base + {{(PRESCALE_W-1){1'b0}}, carry};

  // Count down, tick at zero and reload
  always_ff @(posedge clk) begin
    if (!nrst) begin
      count <= '0;
      acc <= '0;
      tick <= 1'b0;
    end else if (count == '0) begin
      count <= reload;
      acc <= acc_sum[FRAC_W-1:0];
      tick <= 1'b1;
    end else begin
      count <= count - {{(PRESCALE_W-1){1'b0}}, 1'b1};
      tick <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// [hw/cme_channel_mode_engine.sv]
// Four-channel mode engine: UART, serial engine and bit-bang ports
`timescale 1ns/1ps
`default_nettype none

module cme_channel_mode_engine #(
  parameter int NUM_CH = cme_pkg::NUM_CH,
  parameter int SSE_CH = cme_pkg::SSE_CH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Mode selection, one strobe per channel
  input wire logic [NUM_CH-1:0] mode_write,
  input wire logic [NUM_CH-1:0][7:0] mode_value,
  // Line setting and bit-bang directions
  input wire cme_pkg::cme_line_cfg_type [NUM_CH-1:0] line_cfg,
  input wire logic [NUM_CH-1:0][7:0] pin_dir,
  // USB suspend state
  input wire logic usb_suspend,
  output logic power_enable_n,
  // Host to device FIFO side
  input wire logic [NUM_CH-1:0] h2d_valid,
  input wire logic [NUM_CH-1:0][7:0] h2d_data,
  output logic [NUM_CH-1:0] h2d_ready,
  // Device to host FIFO side
  output logic [NUM_CH-1:0] d2h_valid,
  output logic [NUM_CH-1:0][7:0] d2h_data,
  input wire logic [NUM_CH-1:0] d2h_ready,
  // UART line outputs
  output logic [NUM_CH-1:0] uart_txd,
  output logic [NUM_CH-1:0] rs485_tx_drive_enable,
  // Parallel pins, three signals each
  input wire logic [NUM_CH-1:0][7:0] pin_in,
  output logic [NUM_CH-1:0][7:0] pin_out,
  output logic [NUM_CH-1:0][7:0] pin_oe_n
);

  // Legal mode for a channel; unknown codes fall back to UART
  function automatic logic [7:0] legal_mode(input logic [7:0] code,
                                            input logic has_sse);
    case (code)
      cme_pkg::MODE_ASYNC_BB: legal_mode = cme_pkg::MODE_ASYNC_BB;
      cme_pkg::MODE_SYNC_BB: legal_mode = cme_pkg::MODE_SYNC_BB;
      cme_pkg::MODE_SSE:
        legal_mode = has_sse ? cme_pkg::MODE_SSE : cme_pkg::MODE_UART;
      default: legal_mode = cme_pkg::MODE_UART;
    endcase
  endfunction

  // Active-low drive mask of the pins for a mode
  function automatic logic [7:0] drive_n(input logic [7:0] mode,
                                         input logic [7:0] dir);
    case (mode)
      cme_pkg::MODE_ASYNC_BB: drive_n = ~dir;
      cme_pkg::MODE_SYNC_BB: drive_n = ~dir;
      cme_pkg::MODE_SSE: drive_n = ~cme_pkg::SSE_OUT_MASK;
      default: drive_n = 8'hFF;
    endcase
  endfunction

  // Suspend input synchroniser, three stages
  logic susp_s1;
  logic susp_s2;
  logic susp_s3;
  logic susp_filt;  // Accepted suspend level

  // Suspend sync and power enable; high turns external parts off
  always_ff @(posedge clk) begin
    if (!nrst) begin
      susp_s1 <= 1'b0;
      susp_s2 <= 1'b0;
      susp_s3 <= 1'b0;
      susp_filt <= 1'b0;
      power_enable_n <= 1'b1;
    end else begin
      susp_s1 <= usb_suspend;
      susp_s2 <= susp_s1;
      susp_s3 <= susp_s2;
      if (susp_s2 == susp_s3) begin
        susp_filt <= susp_s3;
      end
      power_enable_n <= susp_filt;
    end
  end

  // One independent engine per channel
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
    localparam logic HAS_SSE = (ch < SSE_CH);

    logic [7:0] mode;                 // Active mode code
    cme_pkg::cme_state_type state;    // Sequencer state
    logic tick;                       // Baud tick
    logic [7:0] p_s1;                 // Pin sync stages
    logic [7:0] p_s2;
    logic [7:0] p_s3;
    logic [7:0] pins;                 // Accepted pin levels
    logic [7:0] out_reg;              // Driven pin values
    logic [10:0] shreg;               // UART frame shifter
    logic [3:0] bitcnt;               // UART bits left
    logic [3:0] subcnt;               // Ticks within a bit
    logic [2:0] settle;               // Sync bit-bang settle count
    logic [7:0] op;                   // Pending engine opcode
    logic [7:0] div;                  // Serial clock divisor
    logic [7:0] halfcnt;              // Cycles left in half period
    logic adapt;                      // Adaptive clocking on
    logic [7:0] sse_tx;               // Engine transmit byte
    logic [7:0] sse_rx;               // Engine receive byte
    logic [2:0] sse_bit;              // Engine bits left minus one

    // Per-channel baud generator
    cme_baud_tick #(
      .PRESCALE_W(cme_pkg::PRESCALE_W),
      .FRAC_W(cme_pkg::FRAC_W)
    ) u_baud (
      .clk(clk),
      .nrst(nrst),
      .prescale(line_cfg[ch].baud.prescale),
      .frac(line_cfg[ch].baud.frac),
      .tick(tick)
    );

    // Handshake decode
    wire idle = (state == cme_pkg::ST_IDLE);
    wire room = !d2h_valid[ch];  // Return slot free
    wire is_uart = (mode == cme_pkg::MODE_UART);
    wire is_async = (mode == cme_pkg::MODE_ASYNC_BB);
    wire is_sync = (mode == cme_pkg::MODE_SYNC_BB);
    wire is_sse = (mode == cme_pkg::MODE_SSE);
    wire ready_async = idle && is_async && tick;
    wire ready_sync = idle && is_sync && room;
    wire ready_sse = is_sse && room &&
      (idle || state == cme_pkg::ST_SSE_ARG);
    wire ready_w = (idle && is_uart) || ready_async || ready_sync ||
      ready_sse;
    // Mode strobe wins; a byte offered then waits instead of being lost
    wire take_ok = ready_w && !mode_write[ch];
    wire take = h2d_valid[ch] && take_ok;
    wire [7:0] byte_in = h2d_data[ch];
    wire [3:0] frame_bits = line_cfg[ch].two_stop ?
      cme_pkg::UART_BITS_TWO_STOP : cme_pkg::UART_BITS_ONE_STOP;
    wire half_done = (halfcnt == 8'h00);
    // Returned clock still high from the last bit; the low half waits
    wire rclk_busy = adapt && pins[cme_pkg::PIN_RCLK];
    // Outputs only where the pin is an output
    wire [7:0] oe_n_w = drive_n(mode, pin_dir[ch]);

    assign h2d_ready[ch] = take_ok;
    assign pin_out[ch] = out_reg;
    assign pin_oe_n[ch] = oe_n_w;

    // Pin sync; a bit changes once stages two and three agree
    always_ff @(posedge clk) begin
      if (!nrst) begin
        p_s1 <= 8'h00;
        p_s2 <= 8'h00;
        p_s3 <= 8'h00;
        pins <= 8'h00;
      end else begin
        p_s1 <= pin_in[ch];
        p_s2 <= p_s1;
        p_s3 <= p_s2;
        pins <= ((p_s2 ~^ p_s3) & p_s3) | ((p_s2 ^ p_s3) & pins);
      end
    end

    // Mode register; reset lands in UART
    always_ff @(posedge clk) begin
      if (!nrst) begin
        mode <= cme_pkg::MODE_UART;
      end else if (mode_write[ch]) begin
        mode <= legal_mode(mode_value[ch], HAS_SSE);
      end
    end

    // Channel sequencer
    always_ff @(posedge clk) begin
      if (!nrst) begin
        state <= cme_pkg::ST_IDLE;
        out_reg <= cme_pkg::RST_PIN_OUT;
        shreg <= 11'h7FF;
        bitcnt <= 4'h0;
        subcnt <= 4'h0;
        settle <= 3'h0;
        op <= 8'h00;
        div <= cme_pkg::RST_DIV;
        halfcnt <= 8'h00;
        adapt <= 1'b0;
        sse_tx <= 8'h00;
        sse_rx <= 8'h00;
        sse_bit <= 3'h0;
        uart_txd[ch] <= 1'b1;
        rs485_tx_drive_enable[ch] <= 1'b0;
        d2h_valid[ch] <= 1'b0;
        d2h_data[ch] <= 8'h00;
      end else if (mode_write[ch]) begin
        // Mode change abandons any sequence in flight
        state <= cme_pkg::ST_IDLE;
        uart_txd[ch] <= 1'b1;
        rs485_tx_drive_enable[ch] <= 1'b0;
        out_reg[cme_pkg::PIN_CLK] <= 1'b0;
        if (mode_value[ch] == cme_pkg::MODE_UART) begin
          adapt <= 1'b0;
          div <= cme_pkg::RST_DIV;
        end
      end else begin
        // Host drains the return slot
        if (d2h_valid[ch] && d2h_ready[ch]) begin
          d2h_valid[ch] <= 1'b0;
        end
        case (state)
          cme_pkg::ST_IDLE: begin
            if (take && is_uart) begin
              // Start bit first, then data LSB first, stop bits high
              shreg <= {2'b11, byte_in, 1'b0};
              bitcnt <= frame_bits;
              subcnt <= 4'h0;
              uart_txd[ch] <= 1'b0;
              rs485_tx_drive_enable[ch] <= 1'b1;
              state <= cme_pkg::ST_UART_TX;
            end else if (take && is_async) begin
              out_reg <= byte_in;
            end else if (take && is_sync) begin
              // Old pin state goes home before the new byte drives
              d2h_data[ch] <= pins;
              d2h_valid[ch] <= 1'b1;
              out_reg <= byte_in;
              settle <= cme_pkg::SBB_SETTLE;
              // Strobe points stay internal, no pins exist for them
              state <= cme_pkg::ST_SETTLE;
            end else if (take && is_sse) begin
              // Opcodes run strictly in stream order
              case (byte_in)
                cme_pkg::OP_SET_DIV: begin
                  op <= byte_in;
                  state <= cme_pkg::ST_SSE_ARG;
                end
                cme_pkg::OP_SHIFT: begin
                  op <= byte_in;
                  state <= cme_pkg::ST_SSE_ARG;
                end
                cme_pkg::OP_ADAPT_ON: adapt <= 1'b1;
                cme_pkg::OP_ADAPT_OFF: adapt <= 1'b0;
                default: begin
                  // Unknown opcodes are skipped
                end
              endcase
            end
          end
          cme_pkg::ST_UART_TX: begin
            if (tick) begin
              subcnt <= subcnt + 4'h1;
              if (subcnt == cme_pkg::UART_OVERSAMPLE_LAST) begin
                shreg <= {1'b1, shreg[10:1]};
                bitcnt <= bitcnt - 4'h1;
                if (bitcnt == 4'h1) begin
                  uart_txd[ch] <= 1'b1;
                  rs485_tx_drive_enable[ch] <= 1'b0;
                  state <= cme_pkg::ST_IDLE;
                end else begin
                  uart_txd[ch] <= shreg[1];
                end
              end
            end
          end
          cme_pkg::ST_SETTLE: begin
            // Setup time, then let the pins reach the sampler
            settle <= settle - 3'h1;
            if (settle == 3'h1) begin
              state <= cme_pkg::ST_IDLE;
            end
          end
          cme_pkg::ST_SSE_ARG: begin
            if (take && op == cme_pkg::OP_SET_DIV) begin
              div <= byte_in;
              state <= cme_pkg::ST_IDLE;
            end else if (take) begin
              // MSB first; first data bit set while clock is low
              out_reg[cme_pkg::PIN_DOUT] <= byte_in[7];
              sse_tx <= {byte_in[6:0], 1'b0};
              sse_bit <= 3'h7;
              halfcnt <= div;
              state <= cme_pkg::ST_SSE_LOW;
            end
          end
          cme_pkg::ST_SSE_LOW: begin
            if (half_done && !rclk_busy) begin
              out_reg[cme_pkg::PIN_CLK] <= 1'b1;
              sse_rx <= {sse_rx[6:0], pins[cme_pkg::PIN_DIN]};
              halfcnt <= div;
              state <= adapt ? cme_pkg::ST_SSE_WAIT_RCLK :
                cme_pkg::ST_SSE_HIGH;
            end else if (!half_done) begin
              halfcnt <= halfcnt - 8'h01;
            end
          end
          cme_pkg::ST_SSE_WAIT_RCLK: begin
            // Data out frozen until the target echoes the clock
            if (pins[cme_pkg::PIN_RCLK]) begin
              state <= cme_pkg::ST_SSE_HIGH;
            end
          end
          cme_pkg::ST_SSE_HIGH: begin
            if (half_done) begin
              out_reg[cme_pkg::PIN_CLK] <= 1'b0;
              if (sse_bit == 3'h0) begin
                // Room was checked before the byte was taken
                d2h_data[ch] <= sse_rx;
                d2h_valid[ch] <= 1'b1;
                state <= cme_pkg::ST_IDLE;
              end else begin
                out_reg[cme_pkg::PIN_DOUT] <= sse_tx[7];
                sse_tx <= {sse_tx[6:0], 1'b0};
                sse_bit <= sse_bit - 3'h1;
                halfcnt <= div;
                state <= cme_pkg::ST_SSE_LOW;
              end
            end else begin
              halfcnt <= halfcnt - 8'h01;
            end
          end
          default: state <= cme_pkg::ST_IDLE;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// [bench/cme_channel_mode_engine_sva.sv]
// Port checker of the channel mode engine, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module cme_channel_mode_engine_sva #(
  parameter int NUM_CH = 4,
  parameter int SSE_CH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Mode and setup inputs, power enable output
  input wire logic [NUM_CH-1:0] mode_write,
  input wire logic [NUM_CH-1:0][7:0] mode_value,
  input wire logic [NUM_CH-1:0][7:0] pin_dir,
  input wire logic usb_suspend,
  input wire logic power_enable_n,
  // Byte streams
  input wire logic [NUM_CH-1:0] h2d_valid,
  input wire logic [NUM_CH-1:0][7:0] h2d_data,
  input wire logic [NUM_CH-1:0] h2d_ready,
  input wire logic [NUM_CH-1:0] d2h_valid,
  // Line and pin outputs
  input wire logic [NUM_CH-1:0] uart_txd,
  input wire logic [NUM_CH-1:0] rs485_tx_drive_enable,
  input wire logic [NUM_CH-1:0][7:0] pin_out,
  input wire logic [NUM_CH-1:0][7:0] pin_oe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Mode of channel 0 as last written; illegal codes never match below
  logic [7:0] mode0;
  wire take0 = h2d_valid[0] & h2d_ready[0] & ~mode_write[0];
  wire sbb0 = mode0 == cme_pkg::MODE_SYNC_BB;
  wire abb0 = mode0 == cme_pkg::MODE_ASYNC_BB;
  // Mode tracker, cleared by reset like the channel
  always_ff @(posedge clk) begin
    if (!nrst) begin
      mode0 <= cme_pkg::MODE_UART;
    end else if (mode_write[0]) begin
      mode0 <= mode_value[0];
    end
  end
  property p_uart_pins;
    mode0 == cme_pkg::MODE_UART |-> pin_oe_n[0] == 8'hFF;
  endproperty
  a_uart_pins: assert property (p_uart_pins) else $error("uart drives pins");
  property p_bb_dir;
    (abb0 | sbb0) |-> pin_oe_n[0] == ~pin_dir[0];
  endproperty
  a_bb_dir: assert property (p_bb_dir) else $error("direction ignored");
  property p_sse_oe;
    mode_write[0] && mode_value[0] == cme_pkg::MODE_SSE
      |=> pin_oe_n[0] == ~cme_pkg::SSE_OUT_MASK;
  endproperty
  a_sse_oe: assert property (p_sse_oe) else $error("engine pins wrong");
  property p_no_sse_ch2;
    mode_write[2] && mode_value[2] == cme_pkg::MODE_SSE |=> pin_oe_n[2] == 8'hFF;
  endproperty
  a_no_sse_ch2: assert property (p_no_sse_ch2) else $error("engine on ch2");
  property p_sbb_drive;
    sbb0 && take0 |=> d2h_valid[0] && pin_out[0] == $past(h2d_data[0]);
  endproperty
  a_sbb_drive: assert property (p_sbb_drive) else $error("sync drive wrong");
  property p_sbb_settle;
    sbb0 && take0 |=> !h2d_ready[0] [*4];
  endproperty
  a_sbb_settle: assert property (p_sbb_settle) else $error("no setup gap");
  property p_sbb_room;
    sbb0 && d2h_valid[0] |-> !h2d_ready[0];
  endproperty
  a_sbb_room: assert property (p_sbb_room) else $error("no return room");
  property p_async_drive;
    abb0 && take0 |=> pin_out[0] == $past(h2d_data[0]);
  endproperty
  a_async_drive: assert property (p_async_drive) else $error("async drive");
  property p_hold;
    (abb0 | sbb0) && !take0 && !mode_write[0] |=> $stable(pin_out[0]);
  endproperty
  a_hold: assert property (p_hold) else $error("pins changed idle");
  property p_tx_idle;
    !rs485_tx_drive_enable[0] |-> uart_txd[0];
  endproperty
  a_tx_idle: assert property (p_tx_idle) else $error("txd without enable");
  property p_tx_start;
    mode0 == cme_pkg::MODE_UART && take0
      |=> !uart_txd[0] && rs485_tx_drive_enable[0];
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("no frame start");
  property p_power_off;
    usb_suspend [*8] |-> power_enable_n;
  endproperty
  a_power_off: assert property (p_power_off) else $error("power stays on");
  property p_power_on;
    !usb_suspend [*8] |-> !power_enable_n;
  endproperty
  a_power_on: assert property (p_power_on) else $error("power stays off");
  // Main scenarios reached
  c_uart: cover property (mode0 == cme_pkg::MODE_UART && take0);
  c_async: cover property (abb0 && take0);
  c_sync: cover property (sbb0 && take0);
endmodule
bind cme_channel_mode_engine cme_channel_mode_engine_sva #(
  .NUM_CH(NUM_CH), .SSE_CH(SSE_CH)) u_sva (.clk, .nrst, .mode_write,
  .mode_value, .pin_dir, .usb_suspend, .power_enable_n, .h2d_valid,
  .h2d_data, .h2d_ready, .d2h_valid, .uart_txd, .rs485_tx_drive_enable,
  .pin_out, .pin_oe_n);
`default_nettype wire

// [bench/cme_pin_model.sv]
// Pin-side target model: pull-ups, serial loopback and returned clock
`timescale 1ns/1ps
`default_nettype none
module cme_pin_model #(
  parameter int RCLK_DLY = 5
) (
  // Clock and stall control
  input wire logic clk,
  input wire logic rclk_stall,
  // Pins of all channels
  input wire logic [3:0][7:0] pin_out,
  input wire logic [3:0][7:0] pin_oe_n,
  output logic [3:0][7:0] pin_in
);
  // Returned clock lags the serial clock by a few cycles
  logic [RCLK_DLY-1:0] rclk_pipe;
  always_ff @(posedge clk) begin
    rclk_pipe <= {rclk_pipe[RCLK_DLY-2:0], pin_out[0][cme_pkg::PIN_CLK]};
  end
  // Undriven pins float high through pull-ups
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      pin_in[c] = pin_out[c] | pin_oe_n[c];
    end
    if (pin_oe_n[0] == ~cme_pkg::SSE_OUT_MASK) begin
      pin_in[0][cme_pkg::PIN_DIN] = pin_out[0][cme_pkg::PIN_DOUT];
      pin_in[0][cme_pkg::PIN_RCLK] = rclk_pipe[RCLK_DLY-1] & ~rclk_stall;
    end
  end
endmodule
`default_nettype wire

// [bench/cme_channel_mode_engine_tb_top.sv]
// Self-checking bench of the channel mode engine
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin errors++; \
  $display("unexpected t=%0t got %h exp %h", $time, (a), (e)); end end
module cme_channel_mode_engine_tb_top;
  // Stimulus, all given values at time zero
  logic clk = 0, nrst = 0, usb_suspend = 0, rclk_stall = 0;
  logic [3:0] mode_write = '0, h2d_valid = '0, d2h_ready = '0;
  logic [3:0][7:0] mode_value = '0, pin_dir = '0, h2d_data = '0;
  cme_pkg::cme_line_cfg_type [3:0] line_cfg = '0;
  // Design outputs
  logic power_enable_n;
  logic [3:0] h2d_ready, d2h_valid, uart_txd, rs485;
  logic [3:0][7:0] d2h_data, pin_in, pin_out, pin_oe_n;
  int errors = 0, n_tests = 0, cycles = 0;
  cme_channel_mode_engine #(.NUM_CH(4), .SSE_CH(2)) uut (.clk(clk),
    .nrst(nrst), .mode_write(mode_write), .mode_value(mode_value),
    .line_cfg(line_cfg), .pin_dir(pin_dir), .usb_suspend(usb_suspend),
    .power_enable_n(power_enable_n), .h2d_valid(h2d_valid),
    .h2d_data(h2d_data), .h2d_ready(h2d_ready), .d2h_valid(d2h_valid),
    .d2h_data(d2h_data), .d2h_ready(d2h_ready), .uart_txd(uart_txd),
    .rs485_tx_drive_enable(rs485), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n));
  cme_pin_model #(.RCLK_DLY(5)) u_model (.clk(clk), .rclk_stall(rclk_stall),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_in(pin_in));
  // 100 ns clock
  initial begin
    forever #50 clk = ~clk;
  end
  // Hang guard, well above the thousand or so cycles needed
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      complete_run();
    end
  end
  task automatic complete_run();
    if (errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Five cycles of reset
  task automatic do_reset();
    @(negedge clk);
    nrst = 0;
    repeat (5) @(negedge clk);
    nrst = 1;
  endtask
  // One-cycle mode strobe
  task automatic set_mode(input int c, input logic [7:0] v);
    @(negedge clk);
    mode_write[c] = 1'b1;
    mode_value[c] = v;
    @(negedge clk);
    mode_write[c] = 1'b0;
  endtask
  // Offer a byte and hold it until ready is seen at an edge
  task automatic send(input int c, input logic [7:0] b);
    int n;
    n = 0;
    @(negedge clk);
    h2d_valid[c] = 1'b1;
    h2d_data[c] = b;
    do begin
      @(posedge clk);
      n++;
    end while (!h2d_ready[c] && n < 2000);
    `CHK(h2d_ready[c], 1'b1)
    @(negedge clk);
    h2d_valid[c] = 1'b0;
  endtask
  // Accept one returned byte and compare it
  task automatic get(input int c, input logic [7:0] e);
    int n;
    n = 0;
    @(negedge clk);
    d2h_ready[c] = 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (!d2h_valid[c] && n < 2000);
    `CHK({d2h_valid[c], d2h_data[c]}, {1'b1, e})
    @(negedge clk);
    d2h_ready[c] = 1'b0;
  endtask
  task automatic t_after_reset();
    `CHK(pin_oe_n, 32'hFFFF_FFFF)
    `CHK(uart_txd, 4'hF)
    `CHK(rs485, 4'h0)
    `CHK({d2h_valid, pin_out}, 36'h0_0000_0000)
    `CHK(power_enable_n, 1'b1)
  endtask
  task automatic t_power();
    usb_suspend = 1'b1;
    repeat (8) @(negedge clk);
    `CHK(power_enable_n, 1'b1)
    usb_suspend = 1'b0;
    repeat (8) @(negedge clk);
    `CHK(power_enable_n, 1'b0)
  endtask
  // Frame of 10 bits at one baud tick per cycle
  task automatic t_uart();
    int n;
    logic [9:0] rx;
    n = 0;
    rx = '0;
    send(0, 8'h5A);
    `CHK({uart_txd[0], rs485[0]}, 2'b01)
    while (rs485[0] && n < 400) begin
      @(negedge clk);
      n++;
      // Mid-bit sample, start bit ends up lowest
      if (n % 16 == 8) begin
        rx = {uart_txd[0], rx[9:1]};
      end
    end
    `CHK(rx, 10'h2B4)
    `CHK(uart_txd[0], 1'b1)
    `CHK(n inside {[150:180]}, 1'b1)
  endtask
  // Async bit-bang paced by a three-cycle tick
  task automatic t_async();
    int t0;
    line_cfg[0].baud.prescale = 14'h0003;
    pin_dir[0] = 8'hF0;
    set_mode(0, cme_pkg::MODE_ASYNC_BB);
    `CHK(pin_oe_n[0], 8'h0F)
    send(0, 8'h3C);
    t0 = cycles;
    `CHK(pin_in[0], 8'h3F)
    send(0, 8'hC3);
    `CHK(cycles - t0, 3)
    `CHK(pin_in[0], 8'hCF)
    repeat (20) @(negedge clk);
    `CHK(pin_in[0], 8'hCF)
  endtask
  // Sync bit-bang: reads lag the writes by one byte
  task automatic t_sync();
    do_reset();
    pin_dir[0] = 8'h0F;
    set_mode(0, cme_pkg::MODE_SYNC_BB);
    // Let the new pin levels pass the input synchroniser first
    repeat (4) @(negedge clk);
    send(0, 8'h55);
    `CHK(pin_in[0], 8'hF5)
    repeat (10) @(negedge clk);
    `CHK({h2d_ready[0], d2h_valid[0]}, 2'b01)
    get(0, 8'hF0);
    send(0, 8'hAA);
    get(0, 8'hF5);
    send(0, 8'hAA);
    get(0, 8'hFA);
  endtask
  task automatic t_modes();
    set_mode(2, cme_pkg::MODE_SSE);
    `CHK(pin_oe_n[2], 8'hFF)
    pin_dir[3] = 8'h81;
    set_mode(3, cme_pkg::MODE_ASYNC_BB);
    `CHK(pin_oe_n[3], 8'h7E)
    set_mode(3, cme_pkg::MODE_SYNC_BB);
    `CHK(pin_oe_n[3], 8'h7E)
    set_mode(0, cme_pkg::MODE_SSE);
    `CHK(pin_oe_n[0], 8'hFC)
    set_mode(0, cme_pkg::MODE_UART);
    `CHK(pin_oe_n[0], 8'hFF)
  endtask
  // Engine shift through the loopback, with the returned clock held back
  task automatic t_engine(input logic adapt);
    set_mode(0, cme_pkg::MODE_SSE);
    rclk_stall = 1'b1;
    send(0, cme_pkg::OP_SET_DIV);
    send(0, 8'h07);
    if (adapt) begin
      send(0, cme_pkg::OP_ADAPT_ON);
    end
    send(0, cme_pkg::OP_SHIFT);
    send(0, 8'hA5);
    repeat (300) @(negedge clk);
    `CHK(d2h_valid[0], !adapt)
    rclk_stall = 1'b0;
    get(0, 8'hA5);
  endtask
  initial begin
    line_cfg[0].baud.prescale = 14'h0001;
    do_reset();
    t_after_reset();
    t_power();
    t_uart();
    t_async();
    t_sync();
    t_modes();
    t_engine(1'b1);
    do_reset();
    t_engine(1'b0);
    complete_run();
  end
endmodule
`undef CHK
`default_nettype wire
